// ---- include/rst_pkg.sv ----
package rst_pkg;
	localparam int unsigned CLK_HZ           = 250_000_000;
	// start-up takes about one minute, a reset about one second
	localparam int unsigned STARTUP_TIME_S   = 60;
	localparam int unsigned RESET_TIME_S     = 1;
	localparam int unsigned MONITOR_TIME_S   = 1;
	localparam int unsigned WINDOW_TIME_S    = 3600;
	localparam longint unsigned STARTUP_CYC  = longint'(STARTUP_TIME_S) * CLK_HZ;
	localparam longint unsigned RESET_CYC    = longint'(RESET_TIME_S) * CLK_HZ;
	localparam longint unsigned MONITOR_CYC  = longint'(MONITOR_TIME_S) * CLK_HZ;
	localparam longint unsigned WINDOW_CYC   = longint'(WINDOW_TIME_S) * CLK_HZ;
	localparam int unsigned FAIL_LIMIT       = 3;
	localparam int unsigned RESET_LIMIT      = 4;
	localparam int unsigned NUM_PROC         = 3;
	localparam int unsigned NUM_BREAKER      = 2;

	typedef enum {
		ST_SELFTEST,
		ST_INIT,
		ST_RUN,
		ST_RESETTING,
		ST_HALT_CRIT,
		ST_SHUTDOWN
	} rst_state_e;

	// display message codes
	localparam logic [1:0] MSG_BLANK = 2'h0;
	localparam logic [1:0] MSG_INIT  = 2'h1;
	localparam logic [1:0] MSG_DIAG  = 2'h2;
	localparam logic [1:0] MSG_ERROR = 2'h3;

	typedef struct packed {
		logic       valid;
		logic [1:0] breakerIdx;
		logic       energized;
	} rst_trip_evt_s;

	typedef struct packed {
		logic greenLamp;
		logic redLamp;
		logic critAlarm;
		logic nonCritAlarm;
	} rst_alarm_s;
endpackage

// ---- design/rst_retry_filter.sv ----
`timescale 1ns/1ps
// declares a component failed after consecutive failing runs
module rst_retry_filter #(
	parameter int unsigned N      = 4,
	parameter int unsigned LIMIT  = 3
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         srst,
	// test results
	input  wire logic [N-1:0] testDone,
	input  wire logic [N-1:0] testFail,
	input  wire logic         clearAll,
	// verdicts
	output logic      [N-1:0] failed
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			logic [1:0] cnt_reg;
			logic       fail_reg;
			wire        hitNow = testDone[i] && testFail[i] && (cnt_reg == 2'(LIMIT - 1));
			always_ff @(posedge sys_clk) begin
				if (srst || clearAll) begin
					cnt_reg  <= 2'h0;
					fail_reg <= 1'b0;
				end else if (testDone[i]) begin
					if (!testFail[i]) begin
						cnt_reg <= 2'h0;
					end else if (hitNow) begin
						fail_reg <= 1'b1;
						cnt_reg  <= 2'h0;
					end else begin
						cnt_reg <= cnt_reg + 2'h1;
					end
				end
			end
			assign failed[i] = fail_reg;
		end
	endgenerate
endmodule

// ---- design/rst_supervisor.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: after trip, log each breaker's trip current
// RULE_02: protection waits for all three processors
// RULE_03: check firmware compatibility and model number
// RULE_04: critical start-up failure halts, alarm, message
// RULE_05: read current rating, then enable outputs
// RULE_06: green lamp decided from all results
// RULE_07: initializing message, then blank and acquire
// RULE_08: start-up lasts about one minute
// RULE_09: background tests only while processor idle
// RULE_10: background failure declared after three in row
// RULE_11: critical run-time failure forces self-reset
// RULE_12: malfunction reset reruns only related tests
// RULE_13: successful reset leaves no trace
// RULE_14: red lamp during reset; failure shuts down
// RULE_15: fifth reset in hour halts as critical
// RULE_16: reset procedure lasts about one second
// RULE_17: foreground tests on idle port, three failures
// RULE_18: trip continuity runs as foreground test
// RULE_19: pickup without detector one second alarms
// RULE_20: operator panel lamp test on request
// RULE_21: monitor timer restarts when condition clears
// RULE_22: reset count rolls hourly, cleared by power-up
module rst_supervisor
	import rst_pkg::*;
#(
	parameter longint unsigned STARTUP_CYCLES = STARTUP_CYC,
	parameter longint unsigned RESET_CYCLES   = RESET_CYC,
	parameter longint unsigned MONITOR_CYCLES = MONITOR_CYC,
	parameter longint unsigned WINDOW_CYCLES  = WINDOW_CYC,
	parameter int unsigned     NBG            = 4,
	parameter int unsigned     NFG            = 4
) (
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    srst,
	input  wire logic                    powerOnReset,
	// start-up results from processors
	input  wire logic [NUM_PROC-1:0]     procTestDone,
	input  wire logic [NUM_PROC-1:0]     procTestPass,
	input  wire logic                    firmwareCompatible,
	input  wire logic                    modelMatches,
	input  wire logic                    displayReady,
	input  wire logic                    ratingValid,
	input  wire logic                    ratingIs5A,
	// run-time test results
	input  wire logic [NUM_PROC-1:0]     procIdle,
	input  wire logic [NBG-1:0]          bgTestDone,
	input  wire logic [NBG-1:0]          bgTestFail,
	input  wire logic [NBG-1:0]          bgCritical,
	input  wire logic [NFG-1:0]          fgPortIdle,
	input  wire logic [NFG-1:0]          fgTestDone,
	input  wire logic [NFG-1:0]          fgTestFail,
	// trip current sense and continuous monitor
	input  wire logic                    tripIssued,
	input  wire logic [NUM_BREAKER-1:0]  tripCurrentSensed,
	input  wire logic [3:0]              unitPickedUp,
	input  wire logic                    faultDetector,
	input  wire logic                    lampTestReq,
	// grants and enables
	output logic [NUM_PROC-1:0]          bgTestGrant,
	output logic [NFG-1:0]               fgTestGrant,
	output logic                         protectionEnable,
	output logic                         outputsEnable,
	output logic                         acquisitionEnable,
	output logic                         commsEnable,
	output logic                         saveStatus,
	output logic                         rating5A,
	output logic [NBG-1:0]               rerunMask,
	// lamps, alarms, display, events
	output rst_alarm_s                   alarms,
	output logic [1:0]                   displayMsg,
	output rst_trip_evt_s                tripEvent,
	output logic                         monitorEvent,
	output logic [2:0]                   resetCount
);
	import rst_pkg::*;

	rst_state_e    state_reg, state_next;
	// wide enough for the full one-minute start-up count at the system clock
	logic [39:0]   timer_reg;
	logic [31:0]   monTimer_reg;
	logic [39:0]   winTimer_reg;
	logic [2:0]    resetCnt_reg;
	logic          malfReset_reg;
	logic [NBG-1:0] rerun_reg;
	logic          tripPend_reg;
	logic [NUM_BREAKER-1:0] evtPend_reg;
	rst_alarm_s    alarms_reg;
	logic [1:0]    msg_reg;
	rst_trip_evt_s tripEvt_reg;
	logic          monEvt_reg, monLatched_reg;
	logic [NUM_PROC-1:0] bgGrant_reg;
	logic [NFG-1:0] fgGrant_reg;
	logic          prot_reg, outEn_reg, acq_reg, comms_reg, save_reg, r5_reg;

	logic [NBG-1:0] bgFailed;
	logic [NFG-1:0] fgFailed;

	wire allProcDone  = &procTestDone;
	wire allProcPass  = &procTestPass;
	wire startupOk    = allProcDone && allProcPass && firmwareCompatible && modelMatches; // RULE_02 RULE_03
	wire startupBad   = allProcDone && !startupOk;
	wire bgCritFail   = |(bgFailed & bgCritical);
	wire anyFail      = (|bgFailed) || (|fgFailed);
	wire timerExpired = (state_reg == ST_RESETTING) ? (timer_reg >= 40'(RESET_CYCLES))
	                                                : (timer_reg >= 40'(STARTUP_CYCLES));
	wire overLimit    = (resetCnt_reg >= 3'(RESET_LIMIT));
	wire pickupNoFd   = (|unitPickedUp) && !faultDetector;
	wire monExpire    = pickupNoFd && (monTimer_reg >= 32'(MONITOR_CYCLES - 1));
	wire windowEnd    = (winTimer_reg >= 40'(WINDOW_CYCLES - 1));
	wire inRun        = (state_reg == ST_RUN);
	wire inHalt       = (state_reg == ST_HALT_CRIT) || (state_reg == ST_SHUTDOWN);

	rst_retry_filter #(
		.N     (NBG),
		.LIMIT (FAIL_LIMIT)
	) u_bg (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.testDone (bgTestDone & {NBG{inRun}}),
		.testFail (bgTestFail),
		.clearAll (state_reg == ST_RESETTING),
		.failed   (bgFailed)
	); // RULE_10

	rst_retry_filter #(
		.N     (NFG),
		.LIMIT (FAIL_LIMIT)
	) u_fg (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.testDone (fgTestDone & fgPortIdle & {NFG{inRun}}),
		.testFail (fgTestFail),
		.clearAll (state_reg == ST_RESETTING),
		.failed   (fgFailed)
	); // RULE_17 RULE_18

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_SELFTEST: begin
				if (startupBad) begin
					state_next = ST_HALT_CRIT; // RULE_04
				end else if (startupOk && ratingValid) begin
					state_next = ST_INIT; // RULE_05
				end
			end
			ST_INIT: begin
				if (timerExpired || malfReset_reg) begin
					state_next = ST_RUN; // RULE_08
				end
			end
			ST_RUN: begin
				if (bgCritFail) begin
					state_next = overLimit ? ST_HALT_CRIT : ST_RESETTING; // RULE_11 RULE_15
				end
			end
			ST_RESETTING: begin
				if (startupBad) begin
					state_next = ST_SHUTDOWN; // RULE_14
				end else if (timerExpired && startupOk) begin
					state_next = ST_RUN; // RULE_16 RULE_13
				end
			end
			ST_HALT_CRIT: state_next = ST_HALT_CRIT;
			ST_SHUTDOWN:  state_next = ST_SHUTDOWN;
			default:      state_next = ST_SELFTEST;
		endcase
	end

	// start-up and reset sequencing
	always_ff @(posedge sys_clk) begin
		if (srst || powerOnReset) begin
			state_reg     <= ST_SELFTEST;
			timer_reg     <= 40'h0;
			malfReset_reg <= 1'b0;
			rerun_reg     <= '0;
		end else begin
			state_reg <= state_next;
			timer_reg <= (state_next != state_reg) ? 40'h0 : timer_reg + 40'h1;
			if (state_reg == ST_RUN && state_next == ST_RESETTING) begin
				malfReset_reg <= 1'b1; // RULE_12
				rerun_reg     <= bgFailed & bgCritical; // RULE_12
			end else if (state_next == ST_RUN) begin
				rerun_reg <= '0;
			end
		end
	end

	// rolling hourly reset counter, survives malfunction resets
	always_ff @(posedge sys_clk) begin
		if (powerOnReset) begin
			resetCnt_reg <= 3'h0; // RULE_22
			winTimer_reg <= 40'h0;
		end else begin
			winTimer_reg <= windowEnd ? 40'h0 : winTimer_reg + 40'h1; // RULE_22
			if (state_reg == ST_RUN && bgCritFail && !overLimit) begin
				resetCnt_reg <= resetCnt_reg + 3'h1; // RULE_15
			end else if (state_reg == ST_RUN && bgCritFail) begin
				resetCnt_reg <= resetCnt_reg;
			end else if (windowEnd) begin
				resetCnt_reg <= 3'h0;
			end
		end
	end

	// outputs, lamps, display
	always_ff @(posedge sys_clk) begin
		if (srst || powerOnReset) begin
			prot_reg   <= 1'b0;
			outEn_reg  <= 1'b0;
			acq_reg    <= 1'b0;
			comms_reg  <= 1'b0;
			save_reg   <= 1'b0;
			r5_reg     <= 1'b0;
			msg_reg    <= MSG_BLANK;
			alarms_reg <= '0;
			bgGrant_reg <= '0;
			fgGrant_reg <= '0;
		end else begin
			prot_reg  <= (state_next == ST_RUN); // RULE_02
			outEn_reg <= (state_next == ST_INIT) || (state_next == ST_RUN); // RULE_05
			acq_reg   <= (state_next == ST_RUN); // RULE_07
			comms_reg <= (state_next != ST_SELFTEST && state_next != ST_SHUTDOWN); // RULE_04
			save_reg  <= (state_next == ST_HALT_CRIT) && (state_reg != ST_HALT_CRIT); // RULE_04
			if (state_reg == ST_SELFTEST && ratingValid) begin
				r5_reg <= ratingIs5A; // RULE_05
			end
			bgGrant_reg <= procIdle & {NUM_PROC{inRun}}; // RULE_09
			fgGrant_reg <= fgPortIdle & {NFG{inRun}}; // RULE_17
			case (state_next)
				ST_SELFTEST: msg_reg <= displayReady ? MSG_INIT : MSG_BLANK; // RULE_07
				ST_INIT:     msg_reg <= MSG_INIT;
				ST_RESETTING: msg_reg <= MSG_ERROR; // RULE_14
				ST_SHUTDOWN: msg_reg <= MSG_ERROR;
				ST_HALT_CRIT: msg_reg <= MSG_DIAG; // RULE_04
				default:     msg_reg <= MSG_BLANK; // RULE_07
			endcase
			alarms_reg.critAlarm <= (state_next == ST_HALT_CRIT) ||
			                        (state_next == ST_SHUTDOWN); // RULE_04 RULE_13
			alarms_reg.redLamp   <= lampTestReq || (state_next == ST_RESETTING) ||
			                        inHalt; // RULE_14 RULE_20
			alarms_reg.greenLamp <= lampTestReq ||
			                        ((state_next == ST_RUN) && !anyFail); // RULE_06 RULE_20
			alarms_reg.nonCritAlarm <= monLatched_reg || monExpire ||
			                           ((|fgFailed) && inRun); // RULE_19
		end
	end

	// continuous monitor persistence
	always_ff @(posedge sys_clk) begin
		if (srst || powerOnReset) begin
			monTimer_reg   <= 32'h0;
			monEvt_reg     <= 1'b0;
			monLatched_reg <= 1'b0;
		end else begin
			monEvt_reg <= 1'b0;
			if (!pickupNoFd || !inRun) begin
				monTimer_reg <= 32'h0; // RULE_21
			end else if (monExpire) begin
				monTimer_reg   <= 32'h0;
				monEvt_reg     <= 1'b1; // RULE_19
				monLatched_reg <= 1'b1;
			end else begin
				monTimer_reg <= monTimer_reg + 32'h1;
			end
		end
	end

	// trip current reporting, one event per breaker after a trip
	always_ff @(posedge sys_clk) begin
		if (srst || powerOnReset) begin
			tripPend_reg <= 1'b0;
			evtPend_reg  <= '0;
			tripEvt_reg  <= '0;
		end else begin
			tripEvt_reg.valid <= 1'b0;
			if (tripIssued) begin
				evtPend_reg <= '1; // RULE_01
			end else if (evtPend_reg[0]) begin
				tripEvt_reg.valid      <= 1'b1;
				tripEvt_reg.breakerIdx <= 2'h1; // RULE_01
				tripEvt_reg.energized  <= tripCurrentSensed[0];
				evtPend_reg[0]         <= 1'b0;
			end else if (evtPend_reg[1]) begin
				tripEvt_reg.valid      <= 1'b1;
				tripEvt_reg.breakerIdx <= 2'h2; // RULE_01
				tripEvt_reg.energized  <= tripCurrentSensed[1];
				evtPend_reg[1]         <= 1'b0;
			end
			tripPend_reg <= |evtPend_reg;
		end
	end

	assign bgTestGrant       = bgGrant_reg;
	assign fgTestGrant       = fgGrant_reg;
	assign protectionEnable  = prot_reg;
	assign outputsEnable     = outEn_reg;
	assign acquisitionEnable = acq_reg;
	assign commsEnable       = comms_reg;
	assign saveStatus        = save_reg;
	assign rating5A          = r5_reg;
	assign rerunMask         = rerun_reg;
	assign alarms            = alarms_reg;
	assign displayMsg        = msg_reg;
	assign tripEvent         = tripEvt_reg;
	assign monitorEvent      = monEvt_reg;
	assign resetCount        = resetCnt_reg;
endmodule

// ---- dv/rst_supervisor_props.sv ----
`timescale 1ns/1ps
module rst_supervisor_props
	import rst_pkg::*;
#(
	parameter longint unsigned MONITOR_CYCLES = MONITOR_CYC
) (
	// clock and reset
	input wire logic                sys_clk,
	input wire logic                srst,
	// watched inputs and test grants
	input wire logic [NUM_PROC-1:0] procTestPass,
	input wire logic                firmwareCompatible,
	input wire logic                modelMatches,
	input wire logic                tripIssued,
	input wire logic [3:0]          unitPickedUp,
	input wire logic                faultDetector,
	input wire logic                lampTestReq,
	input wire logic [NUM_PROC-1:0] procIdle,
	input wire logic [3:0]          fgPortIdle,
	input wire logic [NUM_PROC-1:0] bgTestGrant,
	input wire logic [3:0]          fgTestGrant,
	// watched outputs
	input wire logic                protectionEnable,
	input wire logic                outputsEnable,
	input wire logic                saveStatus,
	input wire rst_alarm_s          alarms,
	input wire rst_trip_evt_s       tripEvent,
	input wire logic                monitorEvent
);
	logic [15:0] monCnt_reg;
	wire         monCond = (|unitPickedUp) && !faultDetector;
	// length of the current pickup-without-detector run
	always_ff @(posedge sys_clk) begin
		monCnt_reg <= (srst || !monCond) ? 16'h0 : monCnt_reg + 16'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	chk_trip_first: assert property (tripIssued |-> ##2
		(tripEvent.valid && tripEvent.breakerIdx == 2'h1)) else $error("breaker one event missing");
	chk_trip_second: assert property (tripIssued |-> ##3
		(tripEvent.valid && tripEvent.breakerIdx == 2'h2)) else $error("breaker two event missing");
	chk_protect_gate: assert property ($rose(protectionEnable) |->
		$past(&procTestPass) && $past(firmwareCompatible && modelMatches))
		else $error("protection enabled without passing tests");
	chk_halt_quiet: assert property (alarms.critAlarm |->
		!protectionEnable && !outputsEnable) else $error("outputs live during halt");
	chk_save_halt: assert property (saveStatus |-> ##[0:1] alarms.critAlarm)
		else $error("status save without critical alarm");
	chk_lamp_test: assert property (lampTestReq |=>
		alarms.greenLamp && alarms.redLamp) else $error("lamp test not shown");
	chk_monitor_time: assert property (monitorEvent |->
		monCnt_reg >= MONITOR_CYCLES - 1 && monCnt_reg <= MONITOR_CYCLES + 2)
		else $error("monitor event at wrong time");
	chk_monitor_alarm: assert property (monitorEvent |-> ##[0:1] alarms.nonCritAlarm)
		else $error("monitor event without alarm");
	chk_bg_grant: assert property ((bgTestGrant & ~$past(procIdle)) == '0)
		else $error("background grant to busy processor");
	chk_fg_grant: assert property ((fgTestGrant & ~$past(fgPortIdle)) == '0)
		else $error("foreground grant to busy port");
endmodule
bind rst_supervisor rst_supervisor_props #(.MONITOR_CYCLES(MONITOR_CYCLES)) u_props (
	.sys_clk, .srst, .procTestPass, .firmwareCompatible, .modelMatches, .tripIssued,
	.unitPickedUp, .faultDetector, .lampTestReq, .protectionEnable, .outputsEnable,
	.saveStatus, .alarms, .tripEvent, .monitorEvent, .procIdle, .fgPortIdle, .bgTestGrant,
	.fgTestGrant);

// ---- dv/rst_proc_model.sv ----
`timescale 1ns/1ps
module rst_proc_model
	import rst_pkg::*;
(
	// clock and restart
	input wire logic                 sys_clk,
	input wire logic                 srst,
	// scenario knobs
	input wire logic                 passAll,
	input wire logic [3:0]           bgFailMask,
	input wire logic [3:0]           fgFailMask,
	input wire logic [7:0]           doneDelay,
	// results toward the supervisor
	output logic     [NUM_PROC-1:0]  procTestDone,
	output logic     [NUM_PROC-1:0]  procTestPass,
	output logic     [NUM_PROC-1:0]  procIdle,
	output logic     [3:0]           bgTestDone,
	output logic     [3:0]           bgTestFail,
	output logic     [3:0]           fgPortIdle,
	output logic     [3:0]           fgTestDone,
	output logic     [3:0]           fgTestFail
);
	logic [7:0] cnt_reg;
	logic [1:0] ph_reg;
	always_ff @(posedge sys_clk) begin
		cnt_reg <= srst ? 8'h0 : (cnt_reg == doneDelay ? cnt_reg : cnt_reg + 8'h1);
		ph_reg  <= srst ? 2'h0 : ph_reg + 2'h1;
	end
	wire allDone = (cnt_reg == doneDelay);
	assign procTestDone = {NUM_PROC{allDone}};
	// pass is meaningless until done, so it toggles
	assign procTestPass = allDone ? {NUM_PROC{passAll}} : {NUM_PROC{ph_reg[0]}};
	assign procIdle     = {NUM_PROC{ph_reg != 2'h0}};
	assign bgTestDone   = {4{ph_reg == 2'h3}};
	assign bgTestFail   = (ph_reg == 2'h3) ? bgFailMask : ~bgFailMask;
	assign fgPortIdle   = {4{ph_reg[0]}};
	assign fgTestDone   = {4{ph_reg == 2'h1}};
	assign fgTestFail   = (ph_reg == 2'h1) ? fgFailMask : ~fgFailMask;
endmodule

// ---- dv/rst_supervisor_bench.sv ----
`timescale 1ns/1ps
module rst_supervisor_bench;
	import rst_pkg::*;
	localparam int MON = 8;
	logic sys_clk, srst, powerOnReset, firmwareCompatible, modelMatches, displayReady;
	logic ratingValid, ratingIs5A, passAll, tripIssued, faultDetector, lampTestReq;
	logic [3:0] bgFailMask, fgFailMask, bgCritical, unitPickedUp, rerunMask;
	logic [3:0] bgTestDone, bgTestFail, fgPortIdle, fgTestDone, fgTestFail, fgTestGrant;
	logic [2:0] procTestDone, procTestPass, procIdle, bgTestGrant, resetCount;
	logic [7:0] doneDelay;
	logic [1:0] tripCurrentSensed, displayMsg;
	logic protectionEnable, outputsEnable, acquisitionEnable, commsEnable;
	logic saveStatus, rating5A, monitorEvent;
	rst_alarm_s alarms;
	rst_trip_evt_s tripEvent;
	int n_errors, checks_done, seed, i;
	rst_supervisor #(.STARTUP_CYCLES(20), .RESET_CYCLES(10), .MONITOR_CYCLES(MON),
		.WINDOW_CYCLES(2000)) uut (.sys_clk, .srst, .powerOnReset, .procTestDone,
		.procTestPass, .firmwareCompatible, .modelMatches, .displayReady, .ratingValid,
		.ratingIs5A, .procIdle, .bgTestDone, .bgTestFail, .bgCritical, .fgPortIdle,
		.fgTestDone, .fgTestFail, .tripIssued, .tripCurrentSensed, .unitPickedUp,
		.faultDetector, .lampTestReq, .bgTestGrant, .fgTestGrant, .protectionEnable,
		.outputsEnable, .acquisitionEnable, .commsEnable, .saveStatus, .rating5A,
		.rerunMask, .alarms, .displayMsg, .tripEvent, .monitorEvent, .resetCount);
	rst_proc_model pm (.sys_clk, .srst, .passAll, .bgFailMask, .fgFailMask, .doneDelay,
		.procTestDone, .procTestPass, .procIdle, .bgTestDone, .bgTestFail, .fgPortIdle,
		.fgTestDone, .fgTestFail);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	function automatic logic [3:0] exp_trip(input int b);
		return {1'b1, 2'(b), tripCurrentSensed[b-1]};
	endfunction
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// waits for protection, critical alarm, red lamp or monitor event
	task automatic wait_on(input int sel, input int lim);
		logic [3:0] w;
		for (int k = 0; k < lim; k++) begin
			w = {monitorEvent, alarms.redLamp, alarms.critAlarm, protectionEnable};
			if (w[sel] === 1'b1) return;
			@(negedge sys_clk);
		end
		n_errors++;
		$display("[FAIL] wait %0d expected 1 seen 0", sel);
		report_and_stop();
	endtask
	task automatic power_up(input logic ok, input logic fw, input logic md);
		@(negedge sys_clk);
		srst = 1'b1;
		powerOnReset = 1'b1;
		passAll = ok;
		firmwareCompatible = fw;
		modelMatches = md;
		bgFailMask = 4'h0;
		doneDelay = 8'(($random(seed) & 15) + 2);
		ratingIs5A = 1'($random(seed));
		tick(2);
		srst = 1'b0;
		powerOnReset = 1'b0;
	endtask
	initial begin
		seed = 32'h9D7D;
		{n_errors, checks_done} = 0;
		{srst, powerOnReset, passAll, firmwareCompatible, modelMatches} = 5'h1F;
		{displayReady, ratingValid, ratingIs5A, bgCritical} = 7'h6F;
		{tripIssued, faultDetector, lampTestReq, tripCurrentSensed} = 5'h00;
		{bgFailMask, fgFailMask, unitPickedUp, doneDelay} = 20'h00004;
		for (i = 0; i < 3; i++) begin
			power_up(i != 0, i != 1, i != 2);
			wait_on(1, 100);
			tick(1);
			cmp("halt protection", 8'h0, protectionEnable);
			cmp("halt message", MSG_DIAG, displayMsg);
			cmp("halt comms", 8'h1, commsEnable);
			$display("start-up failure case %0d done", i);
		end
		power_up(1'b1, 1'b1, 1'b1);
		wait_on(0, 200);
		tick(1);
		cmp("outputs", 8'h1, outputsEnable);
		cmp("rating", ratingIs5A, rating5A);
		cmp("green lamp", 8'h1, alarms.greenLamp);
		cmp("message", MSG_BLANK, displayMsg);
		cmp("acquisition", 8'h1, acquisitionEnable);
		repeat (2) begin
			tripCurrentSensed = 2'($random(seed));
			tripIssued = 1'b1;
			tick(1);
			tripIssued = 1'b0;
			tick(1);
			cmp("breaker one", exp_trip(1), tripEvent);
			tick(1);
			cmp("breaker two", exp_trip(2), tripEvent);
		end
		lampTestReq = 1'b1;
		tick(2);
		cmp("lamp test red", 8'h1, alarms.redLamp);
		lampTestReq = 1'b0;
		tick(2);
		unitPickedUp = 4'h1 << ($random(seed) & 3);
		tick(MON - 2);
		faultDetector = 1'b1;
		tick(1);
		faultDetector = 1'b0;
		tick(MON - 3);
		cmp("alarm after break", 8'h0, alarms.nonCritAlarm);
		wait_on(3, 8);
		tick(1);
		cmp("noncritical alarm", 8'h1, alarms.nonCritAlarm);
		unitPickedUp = 4'h0;
		$display("run-time checks done");
		power_up(1'b1, 1'b1, 1'b1);
		wait_on(0, 200);
		bgFailMask = 4'h1 << ($random(seed) & 3);
		tick(6);
		bgFailMask = 4'h0;
		tick(12);
		cmp("no reset yet", 8'h0, alarms.redLamp);
		bgFailMask = 4'h1 << ($random(seed) & 3);
		wait_on(2, 40);
		tick(1);
		cmp("rerun set", bgFailMask, rerunMask);
		cmp("protection off", 8'h0, protectionEnable);
		bgFailMask = 4'h0;
		wait_on(0, 100);
		tick(1);
		cmp("crit after reset", 8'h0, alarms.critAlarm);
		cmp("msg after reset", MSG_BLANK, displayMsg);
		cmp("count one", 8'h1, resetCount);
		bgFailMask = 4'hF;
		wait_on(1, 600);
		tick(1);
		cmp("count limit", 8'h4, resetCount);
		power_up(1'b1, 1'b1, 1'b1);
		tick(1);
		cmp("count cleared", 8'h0, resetCount);
		$display("reset checks done");
		report_and_stop();
	end
endmodule
